// file: hw/twc_pkg.sv
package twc_pkg;

  typedef logic [31:0] twc_word_t;
  typedef logic [5:0]  twc_addr_t;
  typedef logic [15:0] twc_cnt_t;
  typedef logic [1:0]  twc_sel_t;
  typedef enum logic {DIR_UP, DIR_DOWN} twc_dir_e;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam twc_addr_t ADDR_MODE   = 6'h00;
  localparam twc_addr_t ADDR_CTRL   = 6'h04;
  localparam twc_addr_t ADDR_CMPC   = 6'h08;
  localparam twc_addr_t ADDR_STATUS = 6'h0c;
  localparam twc_addr_t ADDR_COUNT  = 6'h10;

  // ----------------------------------------------------------------
  // mode fields
  // ----------------------------------------------------------------
  localparam int MODE_WAVE_LSB = 13;
  localparam int MODE_EXT_EN   = 12;
  localparam int MODE_SRC_LSB  = 10;
  localparam int MODE_EDGE_LSB = 8;
  localparam int MODE_CDIS     = 7;
  localparam int MODE_CSTOP    = 6;
  localparam twc_word_t MODE_MASK = 32'h0000_7fc0;
  localparam twc_word_t MODE_RST  = 32'h0000_0000;
  localparam twc_cnt_t  CMPC_RST  = 16'hffff;
  localparam twc_cnt_t  CNT_MAX   = 16'hffff;
  localparam twc_cnt_t  CNT_ZERO  = 16'h0000;
  localparam twc_cnt_t  CNT_ONE   = 16'h0001;

  // control command bits and status bits
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_DISABLE = 1;
  localparam int CTRL_TRIGGER = 2;
  localparam int STAT_CLK_EN  = 0;
  localparam int STAT_RUN     = 1;
  localparam int STAT_DOWN    = 2;
  localparam int STAT_B_IN    = 3;
  localparam int STAT_C_HIT   = 4;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam twc_sel_t WAVE_COUNT_UP                     = 2'h0;
  localparam twc_sel_t WAVE_COUNT_UP_THEN_DOWN           = 2'h1;
  localparam twc_sel_t WAVE_COUNT_UP_WITH_COMPARE_C_TRIGGER    = 2'h2;
  localparam twc_sel_t WAVE_COUNT_BIDIR_WITH_COMPARE_C_TRIGGER = 2'h3;
  localparam twc_sel_t SRC_LINE_B = 2'h0;
  localparam twc_sel_t SRC_EXT_0  = 2'h1;
  localparam twc_sel_t SRC_EXT_1  = 2'h2;
  localparam twc_sel_t SRC_EXT_2  = 2'h3;
  localparam twc_sel_t EDGE_NONE  = 2'h0;
  localparam twc_sel_t EDGE_RISE  = 2'h1;
  localparam twc_sel_t EDGE_FALL  = 2'h2;
  localparam twc_sel_t EDGE_BOTH  = 2'h3;

endpackage

// file: hw/twc_edge.sv
`timescale 1ns/10ps
module twc_edge
  import twc_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rstn,
  input  wire logic     i_ce,
  input  wire logic     i_sig,
  input  wire twc_sel_t i_edge_sel,
  output logic          o_evt
);
  logic prev;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev <= 1'b0;
    end else if (i_ce) begin
      prev <= i_sig;
    end
  end

  always_comb begin
    unique case (i_edge_sel)
      EDGE_NONE: o_evt = 1'b0;
      EDGE_RISE: o_evt = i_sig & ~prev;
      EDGE_FALL: o_evt = ~i_sig & prev;
      EDGE_BOTH: o_evt = i_sig ^ prev;
    endcase
  end
endmodule

// file: hw/twc_top.sv
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module twc_top (
  input  wire logic            I_CORE_CLK,
  input  wire logic            I_RSTN,
  input  wire logic            I_CLK_EN,
  input  wire twc_pkg::twc_addr_t I_AVS_ADDRESS,
  input  wire logic            I_AVS_READ,
  input  wire logic            I_AVS_WRITE,
  input  wire twc_pkg::twc_word_t I_AVS_WRITEDATA,
  input  wire logic [3:0]      I_AVS_BYTEENABLE,
  output twc_pkg::twc_word_t   O_AVS_READDATA,
  output logic                 O_AVS_WAITREQUEST,
  input  wire logic            I_COUNT_TICK,
  input  wire logic            I_EXT_CLOCK_IN_0,
  input  wire logic            I_EXT_CLOCK_IN_1,
  input  wire logic            I_EXT_CLOCK_IN_2,
  input  wire logic            I_WAVE_LINE_B,
  output logic                 O_WAVE_LINE_B,
  output logic                 O_WAVE_LINE_B_OE,
  output logic                 O_WAVE_OUT_A
);
  import twc_pkg::*;

  twc_word_t mode;
  twc_cnt_t  cmpc;
  twc_cnt_t  cnt;
  twc_cnt_t  next_cnt;
  twc_dir_e  dir;
  twc_dir_e  next_dir;
  logic      clk_enabled;
  logic      running;
  logic      c_hit;
  twc_word_t rd_word;
  logic      ev_sig;
  logic      evt;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  twc_sel_t wave;
  twc_sel_t src;
  twc_sel_t edge_sel;
  logic     ext_en;
  logic     cdis;
  logic     cstop;
  assign wave     = mode[MODE_WAVE_LSB +: 2];
  assign src      = mode[MODE_SRC_LSB +: 2];
  assign edge_sel = mode[MODE_EDGE_LSB +: 2];
  assign ext_en   = mode[MODE_EXT_EN];
  assign cdis     = mode[MODE_CDIS];
  assign cstop    = mode[MODE_CSTOP];

  function automatic twc_word_t be_merge(twc_word_t old, twc_word_t nw, logic [3:0] be);
    twc_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then accept
  // ----------------------------------------------------------------
  logic wr_go;
  logic rd_cap;
  assign wr_go  = I_CLK_EN && I_AVS_WRITE && !O_AVS_WAITREQUEST;
  assign rd_cap = I_CLK_EN && I_AVS_READ && O_AVS_WAITREQUEST;

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else if (I_CLK_EN) begin
      O_AVS_WAITREQUEST <= !((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST);
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (I_AVS_ADDRESS)
      ADDR_MODE:   rd_word = mode;
      ADDR_CMPC:   rd_word = {16'h0000, cmpc};
      ADDR_COUNT:  rd_word = {16'h0000, cnt};
      ADDR_STATUS: begin
        rd_word[STAT_CLK_EN] = clk_enabled;
        rd_word[STAT_RUN]    = running;
        rd_word[STAT_DOWN]   = (dir == DIR_DOWN);
        rd_word[STAT_B_IN]   = !O_WAVE_LINE_B_OE;
        rd_word[STAT_C_HIT]  = c_hit;
      end
      default:     rd_word = '0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_AVS_READDATA <= '0;
    end else if (rd_cap) begin
      O_AVS_READDATA <= rd_word;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode <= MODE_RST;
      cmpc <= CMPC_RST;
    end else if (wr_go) begin
      if (I_AVS_ADDRESS == ADDR_MODE) begin
        mode <= be_merge(mode, I_AVS_WRITEDATA, I_AVS_BYTEENABLE) & MODE_MASK;
      end
      if (I_AVS_ADDRESS == ADDR_CMPC) begin
        cmpc <= twc_cnt_t'(be_merge({16'h0000, cmpc}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE));
      end
    end
  end

  logic cmd_en;
  logic cmd_dis;
  logic trig_sw;
  assign cmd_en  = wr_go && I_AVS_ADDRESS == ADDR_CTRL && I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[CTRL_ENABLE];
  assign cmd_dis = wr_go && I_AVS_ADDRESS == ADDR_CTRL && I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[CTRL_DISABLE];
  assign trig_sw = wr_go && I_AVS_ADDRESS == ADDR_CTRL && I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[CTRL_TRIGGER];

  // ----------------------------------------------------------------
  // external event
  // ----------------------------------------------------------------
  always_comb begin
    unique case (src)
      SRC_LINE_B: ev_sig = I_WAVE_LINE_B;
      SRC_EXT_0:  ev_sig = I_EXT_CLOCK_IN_0;
      SRC_EXT_1:  ev_sig = I_EXT_CLOCK_IN_1;
      SRC_EXT_2:  ev_sig = I_EXT_CLOCK_IN_2;
    endcase
  end

  twc_edge u_edge (
    .i_clk      (I_CORE_CLK),
    .i_rstn     (I_RSTN),
    .i_ce       (I_CLK_EN),
    .i_sig      (ev_sig),
    .i_edge_sel (edge_sel),
    .o_evt      (evt)
  );

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic     trig;
  logic     tick_go;
  logic     c_arrive;
  twc_cnt_t top;
  assign trig    = I_CLK_EN && (trig_sw || (evt && ext_en));
  assign tick_go = I_CLK_EN && I_COUNT_TICK && clk_enabled && running;
  assign top     = (wave == WAVE_COUNT_BIDIR_WITH_COMPARE_C_TRIGGER) ? cmpc : CNT_MAX;

  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    if (trig) begin
      next_cnt = CNT_ZERO;
      next_dir = DIR_UP;
    end else if (tick_go) begin
      unique case (wave)
        WAVE_COUNT_UP: next_cnt = cnt + CNT_ONE;
        WAVE_COUNT_UP_WITH_COMPARE_C_TRIGGER:
          next_cnt = (cnt == cmpc) ? CNT_ZERO : cnt + CNT_ONE;
        WAVE_COUNT_UP_THEN_DOWN, WAVE_COUNT_BIDIR_WITH_COMPARE_C_TRIGGER: begin
          if (dir == DIR_UP) begin
            if (cnt >= top && cnt != CNT_ZERO) begin
              next_dir = DIR_DOWN;
              next_cnt = cnt - CNT_ONE;
            end else begin
              next_cnt = cnt + CNT_ONE;
            end
          end else if (cnt == CNT_ZERO) begin
            next_dir = DIR_UP;
            next_cnt = CNT_ONE;
          end else begin
            next_cnt = cnt - CNT_ONE;
          end
        end
      endcase
    end
  end

  // counter arriving at C, seen once per arrival
  assign c_arrive = tick_go && !trig && next_cnt == cmpc && cnt != cmpc;

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt <= CNT_ZERO;
      dir <= DIR_UP;
    end else if (I_CLK_EN) begin
      cnt <= next_cnt;
      dir <= next_dir;
    end
  end

  // ----------------------------------------------------------------
  // counter clock gating
  // ----------------------------------------------------------------
  // disable beats enable so a stray enable cannot mask the compare
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      clk_enabled <= 1'b0;
    end else if (I_CLK_EN) begin
      if (cmd_dis || (c_arrive && cdis)) begin
        clk_enabled <= 1'b0;
      end else if (cmd_en) begin
        clk_enabled <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      running <= 1'b0;
    end else if (I_CLK_EN) begin
      if (trig) begin
        running <= 1'b1;
      end else if (c_arrive && cstop) begin
        running <= 1'b0;
      end
    end
  end

  // set wins over clear-on-read
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      c_hit <= 1'b0;
    end else if (I_CLK_EN) begin
      if (c_arrive) begin
        c_hit <= 1'b1;
      end else if (rd_cap && I_AVS_ADDRESS == ADDR_STATUS) begin
        c_hit <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // waveform lines
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_WAVE_OUT_A     <= 1'b0;
      O_WAVE_LINE_B    <= 1'b0;
      O_WAVE_LINE_B_OE <= 1'b0;
    end else if (I_CLK_EN) begin
      O_WAVE_OUT_A     <= O_WAVE_OUT_A ^ evt ^ c_arrive;
      O_WAVE_LINE_B_OE <= (src != SRC_LINE_B);
      if (src != SRC_LINE_B) begin
        O_WAVE_LINE_B <= O_WAVE_LINE_B ^ evt ^ c_arrive;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_stop_at_c;
    c_arrive && cstop ##1 !running;
  endsequence
  sequence s_stopped_trig;
    !running ##1 trig;
  endsequence

  AST_UP_C_WRAP: assert property (tick_go && !trig && wave == WAVE_COUNT_UP_WITH_COMPARE_C_TRIGGER
    && cnt == cmpc |=> cnt == CNT_ZERO) else $error("counter did not wrap at C");
  AST_EVT_RESTART: assert property (I_CLK_EN && evt && ext_en |=> cnt == CNT_ZERO && running)
    else $error("enabled event did not restart counter");
  AST_EVT_NOEFFECT: assert property (I_CLK_EN && evt && !ext_en && !trig_sw && !tick_go
    |=> $stable(cnt) && $stable(running)) else $error("disabled event touched counter");
  AST_EVT_DRIVES_A: assert property (I_CLK_EN && evt && !c_arrive |=> O_WAVE_OUT_A != $past(O_WAVE_OUT_A))
    else $error("event did not act on output A");
  AST_B_DIRECTION: assert property (I_CLK_EN |=> O_WAVE_LINE_B_OE == ($past(src) != SRC_LINE_B))
    else $error("line B direction wrong");
  AST_B_INPUT_QUIET: assert property (src == SRC_LINE_B |=> $stable(O_WAVE_LINE_B))
    else $error("waveform on line B used as input");
  AST_EDGE_NONE: assert property (edge_sel == EDGE_NONE |-> !evt)
    else $error("event seen with edge detection off");
  AST_CLK_DISABLE: assert property (c_arrive && cdis |=> !clk_enabled ##1 (!clk_enabled || $past(cmd_en)))
    else $error("counter clock not disabled at C");
  AST_CLK_STOP: assert property (c_arrive && cstop |-> s_stop_at_c)
    else $error("counter clock not stopped at C");
  AST_STOP_RESTART: assert property (s_stopped_trig |=> running)
    else $error("stopped counter clock not restarted");
  AST_DIS_HOLD: assert property (!clk_enabled && !cmd_en |=> !clk_enabled)
    else $error("disabled counter clock came back alone");
endmodule

// file: tb/twc_far_model.sv
`timescale 1ns/10ps
module twc_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [3:0] i_lvl,
  input  wire logic       i_b_oe,
  input  wire logic       i_b_out,
  output logic [2:0]      o_ext,
  output logic            o_line_b
);
  logic b_drv;
  // board levels move only after an edge, as real sources would
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext <= 3'h0;
      b_drv <= 1'b0;
    end else begin
      o_ext <= i_lvl[3:1];
      b_drv <= i_lvl[0];
    end
  end
  // line b carries the design level while it drives, ours otherwise
  assign o_line_b = i_b_oe ? i_b_out : b_drv;
endmodule

// file: tb/twc_top_bench.sv
`timescale 1ns/10ps
module twc_top_bench;
  import twc_pkg::*;
  typedef struct {twc_sel_t src; twc_sel_t edg; logic oe; int nev;} twc_row_s;
  logic       clk, rstn, ce, rd, wr, tick, b_out, b_oe, wave_a, waitreq, line_b, a0, b0;
  twc_addr_t  addr;
  twc_word_t  wdata, rdata, rv, md;
  logic [3:0] lvl;
  logic [2:0] ext;
  int         errors, n_tests;
  twc_row_s   rows [8] = '{'{SRC_LINE_B, EDGE_RISE, 1'b0, 1}, '{SRC_EXT_0, EDGE_FALL, 1'b1, 1},
                           '{SRC_EXT_1, EDGE_BOTH, 1'b1, 2}, '{SRC_EXT_2, EDGE_NONE, 1'b1, 0},
                           '{SRC_EXT_0, EDGE_RISE, 1'b1, 1}, '{SRC_EXT_1, EDGE_FALL, 1'b1, 1},
                           '{SRC_EXT_2, EDGE_BOTH, 1'b1, 2}, '{SRC_LINE_B, EDGE_BOTH, 1'b0, 2}};
  int         wcnt [4] = '{5, 5, 1, 1};
  logic       wdn  [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  twc_top u_twc_top (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CLK_EN(ce), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_COUNT_TICK(tick),
    .I_EXT_CLOCK_IN_0(ext[0]), .I_EXT_CLOCK_IN_1(ext[1]), .I_EXT_CLOCK_IN_2(ext[2]),
    .I_WAVE_LINE_B(line_b), .O_WAVE_LINE_B(b_out), .O_WAVE_LINE_B_OE(b_oe), .O_WAVE_OUT_A(wave_a));
  twc_far_model u_twc_far_model (.i_clk(clk), .i_rstn(rstn), .i_lvl(lvl), .i_b_oe(b_oe),
    .i_b_out(b_out), .o_ext(ext), .o_line_b(line_b));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input twc_word_t got, input twc_word_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input twc_addr_t a, input twc_word_t d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    rv = rdata;
    if (waitreq !== 1'b0) begin
      errors++;
      $display("FAIL %0t bus never answered", $time);
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  task automatic pulse(input twc_sel_t s);
    @(posedge clk);
    lvl[s] <= 1'b1;
    repeat (3) @(posedge clk);
    lvl[s] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic start;
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h4);
  endtask
  function automatic twc_word_t mode_w(twc_sel_t wv, logic en, twc_sel_t s, twc_sel_t e, logic cd, logic cs);
    return (twc_word_t'(wv) << MODE_WAVE_LSB) | (twc_word_t'(en) << MODE_EXT_EN) | (twc_word_t'(s) << MODE_SRC_LSB)
         | (twc_word_t'(e) << MODE_EDGE_LSB) | (twc_word_t'(cd) << MODE_CDIS) | (twc_word_t'(cs) << MODE_CSTOP);
  endfunction
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, rd, wr, tick, lvl, addr, wdata} = '0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    chk_bit(wave_a, 1'b0);
    chk_bit(b_oe, 1'b0);
    bus(1'b0, ADDR_MODE, 32'h0);
    chk_word(rv, MODE_RST);
    bus(1'b0, ADDR_CMPC, 32'h0);
    chk_word(rv, 32'h0000_ffff);
    bus(1'b1, 6'h3c, 32'h1234_5678);
    bus(1'b0, 6'h3c, 32'h0);
    chk_word(rv, 32'h0);
    $display("test reset done");
    // ordinary cases: every source and every edge kind, trigger enabled
    for (int i = 0; i < 8; i++) begin
      md = mode_w(WAVE_COUNT_UP, 1'b1, rows[i].src, rows[i].edg, 1'b0, 1'b0);
      bus(1'b1, ADDR_MODE, md);
      bus(1'b0, ADDR_MODE, 32'h0);
      chk_word(rv, md);
      start;
      ticks(5);
      a0 = wave_a;
      b0 = b_out;
      pulse(rows[i].src);
      bus(1'b0, ADDR_COUNT, 32'h0);
      chk_word(rv, (rows[i].nev > 0) ? 32'h0 : 32'h5);
      chk_bit(wave_a, a0 ^ rows[i].nev[0]);
      chk_bit(b_out, b0 ^ (rows[i].oe & rows[i].nev[0]));
      chk_bit(b_oe, rows[i].oe);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk_bit(rv[STAT_B_IN], !rows[i].oe);
    end
    $display("test event rows done");
    // event with trigger off still drives a, leaves the counter alone
    bus(1'b1, ADDR_CMPC, 32'h3);
    bus(1'b1, ADDR_MODE, mode_w(WAVE_COUNT_UP, 1'b0, SRC_EXT_1, EDGE_RISE, 1'b0, 1'b0));
    start;
    ticks(2);
    a0 = wave_a;
    pulse(SRC_EXT_1);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h2);
    chk_bit(wave_a, !a0);
    $display("test trigger off done");
    for (int w = 0; w < 4; w++) begin
      bus(1'b1, ADDR_MODE, mode_w(twc_sel_t'(w), 1'b0, SRC_EXT_0, EDGE_NONE, 1'b0, 1'b0));
      start;
      ticks(5);
      bus(1'b0, ADDR_COUNT, 32'h0);
      chk_word(rv, twc_word_t'(wcnt[w]));
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk_bit(rv[STAT_DOWN], wdn[w]);
      chk_bit(rv[STAT_C_HIT], 1'b1);
    end
    $display("test wave modes done");
    bus(1'b1, ADDR_MODE, mode_w(WAVE_COUNT_UP, 1'b0, SRC_EXT_0, EDGE_NONE, 1'b0, 1'b1));
    start;
    ticks(5);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk_word(rv & 32'h3, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h4);
    ticks(2);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h2);
    $display("test stop on c done");
    bus(1'b1, ADDR_MODE, mode_w(WAVE_COUNT_UP, 1'b0, SRC_EXT_0, EDGE_NONE, 1'b1, 1'b0));
    start;
    ticks(5);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(rv[STAT_CLK_EN], 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h4);
    ticks(2);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h0);
    start;
    ticks(2);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h2);
    $display("test disable on c done");
    // ticks while the core is frozen must not count
    bus(1'b1, ADDR_MODE, mode_w(WAVE_COUNT_UP, 1'b0, SRC_EXT_0, EDGE_NONE, 1'b0, 1'b0));
    start;
    ticks(2);
    ce <= 1'b0;
    ticks(3);
    ce <= 1'b1;
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h2);
    $display("test clock enable done");
    // reset in mid-run, line B was an output before it
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(waitreq, 1'b1);
    chk_bit(b_oe, 1'b0);
    chk_bit(wave_a, 1'b0);
    rstn <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk_word(rv, twc_word_t'(1) << STAT_B_IN);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk_word(rv, 32'h0);
    bus(1'b0, ADDR_MODE, 32'h0);
    chk_word(rv, MODE_RST);
    $display("test mid-run reset done");
    complete_run;
  end
endmodule
